// ==== rtbt_pkg.sv ====
// constants and state types shared by the triggered ripple timer files
package rtbt_pkg;

   // system clock period, the base of every cycle count below
   localparam int unsigned CLK_PERIOD_NS = 4;

   // half period of the on-chip timebase oscillator, in nanoseconds like the clock period
   localparam int unsigned OSC_HALF_PERIOD_NS = 1000;

   // half period in clock cycles, rounded up, never below one
   localparam int unsigned OSC_HALF_CYCLES_RAW =
      (OSC_HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] OSC_HALF_CYCLES =
      (OSC_HALF_CYCLES_RAW < 1) ? 16'h0001 : OSC_HALF_CYCLES_RAW[15:0];

   // oscillator level right after a restart, so the first fall lies one half period out
   localparam logic OSC_RESTART_LEVEL = 1'b1;

   // positions of the external pins inside the synchroniser vectors
   localparam int unsigned SYNC_W = 4;
   localparam int unsigned SYNC_TRG = 0;
   localparam int unsigned SYNC_RST = 1;
   localparam int unsigned SYNC_TB = 2;
   localparam int unsigned SYNC_INH = 3;

   // counter chain width and the index of its last stage
   localparam int unsigned STAGES = 8;
   localparam int unsigned STAGE_LAST = 7;

   // chain contents while idle and right after a trigger (every stage toggled)
   localparam logic [7:0] CHAIN_IDLE = 8'h00;
   localparam logic [7:0] CHAIN_START = 8'hFF;

   // falling timebase edges from start until the divide-by-256 output rises again
   localparam int unsigned EDGES_TO_HIGH = 128;

   // state of the timebase oscillator
   typedef struct packed {
      logic [15:0] cnt;   // cycles spent in the current half period
      logic level;        // present oscillator level
   } rtbt_osc_st_t;

   // state of the timer core
   typedef struct packed {
      logic [3:0] s1;      // first synchroniser stage
      logic [3:0] s2;      // second synchroniser stage
      logic trg_prev;      // trigger level one cycle ago
      logic tb_prev;       // selected timebase level one cycle ago
      logic running;       // timing cycle in progress
      logic [7:0] chain;   // counter chain stages
      logic div2;          // divide-by-2 output level
      logic div256;        // divide-by-256 output level
      logic discharge;     // discharge path pulse
      logic tb_oe_n;       // timebase pin output enable, low while driving
      logic [7:0] edges;   // falling edges seen since start, for checks only
   } rtbt_core_st_t;

endpackage

// ==== rtbt_osc.sv ====
// on-chip timebase oscillator: a cycle divider that toggles a square wave
`timescale 1ns/1ps
`default_nettype none

module rtbt_osc
(
   input wire logic sys_clk_i,   // system clock
   input wire logic reset_i,     // synchronous reset, active high
   input wire logic run_i,       // oscillator allowed to run
   input wire logic restart_i,   // restart the phase, one-cycle pulse
   output logic level_o          // square wave timebase level
);

   rtbt_pkg::rtbt_osc_st_t st;       // registered state
   rtbt_pkg::rtbt_osc_st_t next_st;  // next state

   // next-state logic: counting half periods
   always_comb
   begin
      next_st = st;
      if (restart_i)
      begin
         // a start of cycle discharges the timing capacitor: phase restarts
         next_st.cnt = 16'h0000;
         next_st.level = rtbt_pkg::OSC_RESTART_LEVEL;
      end
      else if (!run_i)
      begin
         // inhibited: level frozen, counter parked
         next_st.cnt = 16'h0000;
      end
      else if (st.cnt == rtbt_pkg::OSC_HALF_CYCLES - 16'h0001)
      begin
         next_st.cnt = 16'h0000;
         next_st.level = ~st.level;
      end
      else
      begin
         next_st.cnt = st.cnt + 16'h0001;
      end
   end

   // state register
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         st.cnt <= 16'h0000;
         st.level <= rtbt_pkg::OSC_RESTART_LEVEL;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign level_o = st.level;

   // an inhibited oscillator never moves unless a restart sets it high
   property p_osc_still;
      @(posedge sys_clk_i) disable iff (reset_i)
      (!run_i && !restart_i) |=> $stable(level_o);
   endproperty
   a_osc_still: assert property (p_osc_still) else $error("oscillator moved while inhibited");

endmodule

`default_nettype wire

// ==== rtbt_timer.sv ====
// triggered eight-stage ripple timer core with its timebase selection
//
// What this block does
// - Idle at power-up, or reset high, trigger low
// - Idle: rising trigger edge starts a cycle
// - Start: discharge on, all stages toggle high, outputs low
// - Divide-by-256 rises after 128 falling timebase edges
// - Timebase tied off: oscillator stops, external clock
// - Trigger wins over reset when both asserted
// - Divide outputs driven both ways, no pull-ups
// - Four outputs: timebase, stage one, stage eight, discharge
`timescale 1ns/1ps
`default_nettype none

module rtbt_timer
(
   input wire logic sys_clk_i,             // system clock, 250 MHz
   input wire logic reset_i,               // synchronous power-up reset, active high
   input wire logic trigger_i,             // trigger pin, rising edge starts a cycle
   input wire logic reset_pin_i,           // reset pin, active high level
   input wire logic osc_inhibit_i,         // timing network tied off, oscillator stopped
   input wire logic timebase_pin_i,        // timebase pin as read back from the wire
   output logic timebase_pin_o,            // timebase pin drive value
   output logic timebase_pin_oe_n_o,       // timebase pin enable, low while driving
   output logic div2_o,                    // first stage output, inverter
   output logic div256_o,                  // eighth stage output, inverter
   output logic discharge_o                // discharge path pulse at cycle start
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   rtbt_pkg::rtbt_core_st_t st;       // registered state
   rtbt_pkg::rtbt_core_st_t next_st;  // next state

   logic osc_level;    // internal oscillator level
   logic osc_run;      // oscillator allowed to run
   logic trg_lvl;      // synchronised trigger level
   logic rst_lvl;      // synchronised reset pin level
   logic inh_lvl;      // synchronised inhibit level
   logic tb_now;       // timebase level chosen for counting
   logic trg_rise;     // trigger rising edge this cycle
   logic tb_fall;      // falling timebase edge this cycle
   logic start;        // a timing cycle begins this cycle
   logic go_idle;      // reset pin pulls the block back to idle

   ////////////////////////////////////////////////////////////////////////////
   // pin conditioning and event detection

   // every pin is read only after the second synchroniser stage
   assign trg_lvl = st.s2[rtbt_pkg::SYNC_TRG];
   assign rst_lvl = st.s2[rtbt_pkg::SYNC_RST];
   assign inh_lvl = st.s2[rtbt_pkg::SYNC_INH];

   // with the oscillator inhibited the pin becomes a clock input
   assign osc_run = !inh_lvl;
   assign tb_now = inh_lvl ? st.s2[rtbt_pkg::SYNC_TB] : osc_level;

   // edge detectors work on synchronised levels only
   assign trg_rise = trg_lvl && !st.trg_prev;
   assign tb_fall = st.tb_prev && !tb_now;

   // a trigger edge starts only from idle; a running cycle ignores it
   assign start = !st.running && trg_rise;

   // a high trigger level masks the reset pin entirely
   assign go_idle = rst_lvl && !trg_lvl;

   ////////////////////////////////////////////////////////////////////////////
   // timebase oscillator

   // the oscillator restarts on the same edge that raises discharge; a restart one
   // cycle later could let a fall of the old phase count as the first timed edge
   rtbt_osc u_osc
   (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .run_i     (osc_run),
      .restart_i (start),
      .level_o   (osc_level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb
   begin
      next_st = st;
      // synchroniser chains for all four pins
      next_st.s1 = {osc_inhibit_i, timebase_pin_i, reset_pin_i, trigger_i};
      next_st.s2 = st.s1;
      next_st.trg_prev = trg_lvl;
      next_st.tb_prev = tb_now;
      next_st.discharge = 1'b0;
      // the pin is released whenever an external clock drives it
      next_st.tb_oe_n = inh_lvl;

      if (start)
      begin
         // start wins over the reset pin, since trigger is high here
         next_st.running = 1'b1;
         next_st.chain = rtbt_pkg::CHAIN_START;
         next_st.discharge = 1'b1;
         next_st.edges = 8'h00;
      end
      else if (go_idle)
      begin
         // idle clears every stage so both outputs sit high
         next_st.running = 1'b0;
         next_st.chain = rtbt_pkg::CHAIN_IDLE;
      end
      else if (st.running && tb_fall)
      begin
         // chain counts down, which mirrors the inverted ripple stages
         next_st.chain = st.chain - 8'h01;
         next_st.edges = st.edges + 8'h01;
      end
      else
      begin
         // no event: the chain, running flag and edge count hold
         next_st.chain = st.chain;
      end

      // outputs are inverters on the first and last stage
      next_st.div2 = ~next_st.chain[0];
      next_st.div256 = ~next_st.chain[rtbt_pkg::STAGE_LAST];
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   // power-up reset lands in the idle state with both outputs high
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         st.s1 <= 4'h0;
         st.s2 <= 4'h0;
         st.trg_prev <= 1'b0;
         st.tb_prev <= 1'b0;
         st.running <= 1'b0;
         st.chain <= rtbt_pkg::CHAIN_IDLE;
         st.div2 <= 1'b1;
         st.div256 <= 1'b1;
         st.discharge <= 1'b0;
         st.tb_oe_n <= 1'b0;
         st.edges <= 8'h00;
      end
      else
      begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // the divide outputs are always actively driven high or low
   assign div2_o = st.div2;
   assign div256_o = st.div256;
   // the oscillator level is offered on the timebase pin
   assign timebase_pin_o = osc_level;
   assign timebase_pin_oe_n_o = st.tb_oe_n;
   assign discharge_o = st.discharge;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   property p_reset_idle;
      (rst_lvl && !trg_lvl) |=> (!st.running && div2_o && div256_o);
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("reset pin did not idle block");

   property p_trig_start;
      (!st.running && trg_lvl && !st.trg_prev) |=> st.running ##1 st.running;
   endproperty
   a_trig_start: assert property (p_trig_start) else $error("trigger edge did not start");

   property p_start_outputs;
      $rose(st.running) |-> (!div2_o && !div256_o && discharge_o);
   endproperty
   a_start_outputs: assert property (p_start_outputs) else $error("start did not pull outputs low");

   property p_count_128;
      st.running |-> (div256_o == (st.edges >= rtbt_pkg::EDGES_TO_HIGH));
   endproperty
   a_count_128: assert property (p_count_128) else $error("divide-by-256 out of step with edges");

   property p_inhibit_release;
      inh_lvl |=> timebase_pin_oe_n_o;
   endproperty
   a_inhibit_release: assert property (p_inhibit_release) else $error("pin driven while inhibited");

   property p_trig_priority;
      (st.running && rst_lvl && trg_lvl) |=> st.running;
   endproperty
   a_trig_priority: assert property (p_trig_priority) else $error("reset overrode trigger");

   property p_idle_high;
      !st.running |-> (div2_o && div256_o);
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("idle outputs not high");

   property p_div2_toggle;
      (st.running && tb_fall && !go_idle) |=> (div2_o != $past(div2_o));
   endproperty
   a_div2_toggle: assert property (p_div2_toggle) else $error("divide-by-2 missed an edge");

   property p_div2_hold;
      (st.running && !tb_fall && !go_idle) |=> $stable(div2_o);
   endproperty
   a_div2_hold: assert property (p_div2_hold) else $error("divide-by-2 moved without edge");

   property p_discharge_once;
      discharge_o |=> !discharge_o;
   endproperty
   a_discharge_once: assert property (p_discharge_once) else $error("discharge pulse too long");

endmodule

`default_nettype wire

// ==== rtbt_ext_clk.sv ====
// external clock source model that drives the timebase wire in counter mode
`timescale 1ns/1ps
`default_nettype none

module rtbt_ext_clk
#(
   parameter int HALF = 3
)
(
   input wire logic sys_clk_i,      // system clock
   input wire logic go_i,           // start a burst, one-cycle pulse
   input wire logic [9:0] falls_i,  // falling edges to make in the burst
   output logic clk_o,              // external clock, rests low between bursts
   output logic busy_o              // burst in progress
);
   logic [9:0] left; // falls still to make
   logic [7:0] cnt;  // cycles spent in the half period

   initial
   begin
      clk_o = 1'b0;
      busy_o = 1'b0;
      left = 10'h000;
      cnt = 8'h00;
   end

   ////////////////////////////////////////////////////////////////
   // square wave bursts; the clock stands low outside a burst so a
   // stray edge can never reach the counter between frames
   always @(posedge sys_clk_i)
   begin
      if (go_i)
      begin
         left <= falls_i;
         busy_o <= (falls_i != 10'h000);
         cnt <= 8'h00;
         clk_o <= 1'b0;
      end
      else if (busy_o)
      begin
         if (cnt == 8'(HALF - 1))
         begin
            cnt <= 8'h00;
            clk_o <= ~clk_o;
            if (clk_o && left == 10'h001)
               busy_o <= 1'b0;
            if (clk_o)
               left <= left - 10'h001;
         end
         else
            cnt <= cnt + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ==== rtbt_timer_bench.sv ====
// self-checking bench for the triggered ripple timer
`timescale 1ns/1ps
`default_nettype none

module rtbt_timer_bench;
   logic sys_clk = 1'b0; // system clock, 4 ns
   logic reset = 1'b1;   // power-up reset
   logic trg = 1'b0;     // trigger pin
   logic rpin = 1'b0;    // reset pin as driven by the bench
   logic inh = 1'b0;     // oscillator tied off
   logic oneshot = 1'b0; // route divide-by-256 back to reset
   logic go = 1'b0;      // burst request to the clock source
   logic [9:0] falls = 10'h000; // burst length
   logic ext_clk, busy, tb_o, tb_oe_n, d2, d256, dis;
   logic tb_wire, rst_wire; // resolved pin levels
   int fail_count = 0;
   int check_count = 0;
   typedef struct {logic [9:0] n; logic d2; logic d256;} rtbt_row_t;
   rtbt_row_t rows [7] = '{'{10'h001, 1'b1, 1'b0}, '{10'h002, 1'b0, 1'b0},
      '{10'h07F, 1'b1, 1'b0}, '{10'h080, 1'b0, 1'b1}, '{10'h081, 1'b1, 1'b1},
      '{10'h0FF, 1'b1, 1'b1}, '{10'h100, 1'b0, 1'b0}};

   always #2 sys_clk = ~sys_clk;
   // the pin follows whoever is enabled; the source rests low when idle
   assign tb_wire = tb_oe_n ? ext_clk : tb_o;
   assign rst_wire = oneshot ? d256 : rpin;

   rtbt_timer u_rtbt_timer (.sys_clk_i(sys_clk), .reset_i(reset), .trigger_i(trg),
      .reset_pin_i(rst_wire), .osc_inhibit_i(inh), .timebase_pin_i(tb_wire),
      .timebase_pin_o(tb_o), .timebase_pin_oe_n_o(tb_oe_n), .div2_o(d2),
      .div256_o(d256), .discharge_o(dis));
   rtbt_ext_clk #(.HALF(3)) u_rtbt_ext_clk (.sys_clk_i(sys_clk), .go_i(go),
      .falls_i(falls), .clk_o(ext_clk), .busy_o(busy));

   ////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(string what, logic exp, logic got);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected %s expected %b seen %b", what, exp, got);
      end
   endtask

   // reset pin high with trigger low brings the block back to idle
   task automatic to_idle();
      @(posedge sys_clk);
      trg <= 1'b0;
      rpin <= 1'b1;
      repeat (5) @(posedge sys_clk);
      #1;
      chk("idle div2", 1'b1, d2);
      chk("idle div256", 1'b1, d256);
      @(posedge sys_clk);
      rpin <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask

   // rising trigger; the answer lands three edges later for one cycle
   task automatic start_cycle();
      @(posedge sys_clk);
      trg <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      chk("discharge", 1'b1, dis);
      chk("start div2", 1'b0, d2);
      chk("start div256", 1'b0, d256);
      @(posedge sys_clk);
      #1;
      chk("discharge end", 1'b0, dis);
   endtask

   // external burst of n falls, then the three-edge input path settles
   task automatic burst(input logic [9:0] n);
      @(posedge sys_clk);
      trg <= 1'b0;
      go <= 1'b1;
      falls <= n;
      @(posedge sys_clk);
      go <= 1'b0;
      for (int k = 0; k < 4000; k++)
      begin
         // look after the edge so the source's own update has settled
         @(posedge sys_clk);
         #1;
         if (!busy)
            break;
         if (k == 3999)
         begin
            fail_count++;
            final_report();
         end
      end
      repeat (6) @(posedge sys_clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("reset div2", 1'b1, d2);
      chk("reset div256", 1'b1, d256);
      chk("reset discharge", 1'b0, dis);
      chk("pin driven", 1'b0, tb_oe_n);
      $display("test reset done");
      // internal oscillator: restarts high, first fall toggles divide-by-2 only
      start_cycle();
      chk("restart level", rtbt_pkg::OSC_RESTART_LEVEL, tb_o);
      @(posedge sys_clk);
      trg <= 1'b0;
      for (int k = 0; k < 600 && d2 !== 1'b1; k++)
      begin
         @(posedge sys_clk);
         #1;
         if (k == 599 && d2 !== 1'b1)
         begin
            fail_count++;
            final_report();
         end
      end
      chk("osc div2", 1'b1, d2);
      chk("osc div256", 1'b0, d256);
      chk("osc pin level", 1'b0, tb_o);
      chk("osc pin driven", 1'b0, tb_oe_n);
      $display("test oscillator done");
      @(posedge sys_clk);
      inh <= 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      chk("pin released", 1'b1, tb_oe_n);
      foreach (rows[i])
      begin
         to_idle();
         start_cycle();
         burst(rows[i].n);
         chk("row div2", rows[i].d2, d2);
         chk("row div256", rows[i].d256, d256);
         $display("test count %0d done", rows[i].n);
      end
      // power-up reset in the middle of a cycle returns the block to idle
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("mid reset div2", 1'b1, d2);
      chk("mid reset div256", 1'b1, d256);
      chk("mid reset discharge", 1'b0, dis);
      $display("test mid reset done");
      // trigger and reset together: trigger wins, reset waits for it
      to_idle();
      rpin <= 1'b1;
      start_cycle();
      repeat (6) @(posedge sys_clk);
      #1;
      chk("held div2", 1'b0, d2);
      @(posedge sys_clk);
      trg <= 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
      chk("reset after trigger", 1'b1, d2);
      chk("reset after trigger div256", 1'b1, d256);
      @(posedge sys_clk);
      rpin <= 1'b0;
      $display("test priority done");
      // a second trigger edge while running must not restart the chain
      start_cycle();
      burst(10'h001);
      @(posedge sys_clk);
      trg <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1;
      chk("retrigger div2", 1'b1, d2);
      $display("test retrigger done");
      // one-shot wiring: idles after 128 falls and ignores the rest
      to_idle();
      oneshot <= 1'b1;
      start_cycle();
      burst(10'h082);
      chk("oneshot div2", 1'b1, d2);
      chk("oneshot div256", 1'b1, d256);
      $display("test oneshot done");
      final_report();
   end
endmodule
`default_nettype wire
